/* core/glyph_ram_regs.vh */
// constants for the custom glyph ram lookup block
`ifndef GLYPH_RAM_REGS_VH
`define GLYPH_RAM_REGS_VH
`define GLYPH_DEPTH        64
`define GLYPH_ADDR_W       6
`define GLYPH_PIX_W        5
`define GLYPH_PIX_MSB      4
`define GLYPH_CODE_HI_MSB  7
`define GLYPH_CODE_HI_LSB  4
`define GLYPH_LAST_ROW_7   3'h7
`define GLYPH_CMD_TEXT_BIT 7
`define GLYPH_CMD_GLY_BIT  6
`define TEXT_ADDR_W        7
`define POINTER_RESET      7'h00
`define FONT_TALL_ROWS     4'hA
`endif

/* core/glyph_row_store.v */
// 64 by 8 custom glyph ram with one write port and two read ports
`timescale 1ns/1ns
module glyph_row_store (
	// clock
	input  wire       clk,
	// host side port
	input  wire       wr_en,
	input  wire [5:0] host_addr,
	input  wire [7:0] wr_data,
	output wire [7:0] host_rdata,
	// display side port
	input  wire [5:0] disp_addr,
	output wire [7:0] disp_rdata
);
	// no reset: contents are undefined until the host loads them
	reg [7:0] mem [0:63];

	always @(posedge clk) begin
		if (wr_en)
			mem[host_addr] <= wr_data;
	end

	assign host_rdata = mem[host_addr];
	assign disp_rdata = mem[disp_addr];
endmodule

/* core/glyph_ram_lookup.v */
// custom glyph ram lookup: host access, pointer, and display row lookup
// Notes on behaviour
// - a 64 location by 8 bit glyph ram, host writable.
// - eight patterns with the short font, four with the tall font.
// - character codes 00H to 0FH show the custom glyphs.
// - only the low five bits of a row reach the pixels.
// - bits 5 to 7 and unused locations keep values and read back.
// - after a glyph data write the pointer advances when incrementing.
// - short font: code bits 0 to 2 become glyph address bits 3 to 5; tall font: code bits 1 to 2 become bits 4 to 5.
// - glyph address bits 0 to 2 are the row within a pattern (bits 0 to 3 with the tall font).
// - with the short font, the eighth row is ORed with the cursor pattern.
// - a stored one in the eighth row lights regardless of cursor.
// - row bit 4 is the leftmost pixel, bit 0 the rightmost.
// - custom glyphs are chosen only when code bits 4 to 7 are zero.
// - code bit 3 is ignored in custom glyph selection.
// - a one lights its pixel, a zero leaves it dark.
// - every memory read or write steps the pointer by one.
// - an address instruction loads the pointer and picks the memory.
// - glyph address instruction has bit 6 set, bit 7 clear, 6-bit address.
`timescale 1ns/1ns
`include "glyph_ram_regs.vh"
module glyph_ram_lookup (
	// clock and reset
	input  wire       CLOCK,
	input  wire       SYS_RST,
	// host instruction and data access, one cycle strobes
	input  wire       INSTR_WR,
	input  wire       DATA_WR,
	input  wire       DATA_RD,
	input  wire [7:0] HOST_DATA,
	input  wire       STEP_UP,
	input  wire       FONT_TALL,
	// host results
	output reg  [7:0] DATA_HOLDING_REG,
	output reg        RD_VALID,
	output reg  [6:0] ADDRESS_POINTER,
	output reg        GLYPH_SELECTED,
	output reg        TEXT_ACCESS,
	output reg  [6:0] TEXT_ADDR,
	output reg        TEXT_WR,
	output reg        TEXT_RD,
	output reg  [7:0] TEXT_WDATA,
	// display lookup
	input  wire [7:0] CHAR_CODE,
	input  wire [3:0] ROW_INDEX,
	input  wire [4:0] CURSOR_ROW,
	output reg  [4:0] PIXELS,
	output reg        USE_CUSTOM
);
	reg  [6:0] ptr_next;
	reg        sel_next;
	reg  [5:0] disp_addr;
	reg        is_custom;
	reg  [4:0] row_bits;
	wire [7:0] host_rdata;
	wire [7:0] disp_rdata;
	wire       glyph_wr;
	wire       mem_access;

	// host access goes to whichever memory the last address instruction chose
	// a data write that shares its cycle with an instruction is dropped
	assign glyph_wr   = DATA_WR & ~INSTR_WR & GLYPH_SELECTED;
	assign mem_access = (DATA_WR | DATA_RD) & ~INSTR_WR;

	glyph_row_store u_store (
		.clk        (CLOCK),
		.wr_en      (glyph_wr),
		.host_addr  (ADDRESS_POINTER[5:0]),
		.wr_data    (HOST_DATA),
		.host_rdata (host_rdata),
		.disp_addr  (disp_addr),
		.disp_rdata (disp_rdata)
	);

	// pointer and target selection
	always @* begin
		ptr_next = ADDRESS_POINTER;
		sel_next = GLYPH_SELECTED;
		if (INSTR_WR) begin
			if (HOST_DATA[`GLYPH_CMD_TEXT_BIT]) begin
				ptr_next = HOST_DATA[6:0];
				sel_next = 1'b0;
			end else if (HOST_DATA[`GLYPH_CMD_GLY_BIT]) begin
				ptr_next = {1'b0, HOST_DATA[5:0]};
				sel_next = 1'b1;
			end
		end else if (mem_access) begin
			// glyph addresses wrap in six bits, text addresses in seven
			if (GLYPH_SELECTED) begin
				if (STEP_UP)
					ptr_next = {1'b0, ADDRESS_POINTER[5:0] + 6'h01};
				else
					ptr_next = {1'b0, ADDRESS_POINTER[5:0] - 6'h01};
			end else begin
				if (STEP_UP)
					ptr_next = ADDRESS_POINTER + 7'h01;
				else
					ptr_next = ADDRESS_POINTER - 7'h01;
			end
		end
	end

	always @(posedge CLOCK or posedge SYS_RST) begin
		if (SYS_RST) begin
			ADDRESS_POINTER  <= `POINTER_RESET;
			GLYPH_SELECTED   <= 1'b0;
			DATA_HOLDING_REG <= 8'h00;
			RD_VALID         <= 1'b0;
			TEXT_ACCESS      <= 1'b0;
			TEXT_ADDR        <= 7'h00;
			TEXT_WR          <= 1'b0;
			TEXT_RD          <= 1'b0;
			TEXT_WDATA       <= 8'h00;
		end else begin
			ADDRESS_POINTER <= ptr_next;
			GLYPH_SELECTED  <= sel_next;
			// glyph reads return all eight stored bits
			RD_VALID        <= DATA_RD & ~INSTR_WR & GLYPH_SELECTED;
			if (DATA_RD & ~INSTR_WR & GLYPH_SELECTED)
				DATA_HOLDING_REG <= host_rdata;
			else if (DATA_WR & ~INSTR_WR)
				DATA_HOLDING_REG <= HOST_DATA;
			// text memory accesses are handed out with the pointer value
			TEXT_ACCESS <= mem_access & ~GLYPH_SELECTED;
			TEXT_WR     <= DATA_WR & ~INSTR_WR & ~GLYPH_SELECTED;
			TEXT_RD     <= DATA_RD & ~INSTR_WR & ~GLYPH_SELECTED;
			TEXT_ADDR   <= ADDRESS_POINTER;
			TEXT_WDATA  <= HOST_DATA;
		end
	end

	// display address formation
	always @* begin
		is_custom = (CHAR_CODE[`GLYPH_CODE_HI_MSB:`GLYPH_CODE_HI_LSB] == 4'h0);
		if (FONT_TALL)
			disp_addr = {CHAR_CODE[2:1], ROW_INDEX};
		else
			disp_addr = {CHAR_CODE[2:0], ROW_INDEX[2:0]};
		// upper three bits never reach the pixels
		row_bits = disp_rdata[`GLYPH_PIX_MSB:0];
		// the cursor row is row seven of the short font only
		if (!FONT_TALL && ROW_INDEX[2:0] == `GLYPH_LAST_ROW_7)
			row_bits = row_bits | CURSOR_ROW;
	end

	// one registered stage: pixels follow the code and row by one clock
	always @(posedge CLOCK or posedge SYS_RST) begin
		if (SYS_RST) begin
			PIXELS     <= 5'h00;
			USE_CUSTOM <= 1'b0;
		end else begin
			PIXELS     <= is_custom ? row_bits : 5'h00;
			USE_CUSTOM <= is_custom;
		end
	end
endmodule

/* verification/glyph_ram_lookup_sva.sv */
// port assertions for the glyph lookup block
`timescale 1ns/1ns
module glyph_ram_lookup_sva (
	input wire CLOCK, SYS_RST, INSTR_WR, DATA_WR, DATA_RD, STEP_UP, FONT_TALL,
	input wire [7:0] HOST_DATA, CHAR_CODE,
	input wire [3:0] ROW_INDEX,
	input wire [4:0] CURSOR_ROW, PIXELS,
	input wire [6:0] ADDRESS_POINTER,
	input wire GLYPH_SELECTED, RD_VALID, USE_CUSTOM
);
	default clocking @(posedge CLOCK); endclocking
	default disable iff (SYS_RST);
	wire acc = (DATA_WR | DATA_RD) & !INSTR_WR & GLYPH_SELECTED;
	wire cg = CHAR_CODE[7:4] == 4'h0;
	AST_UP: assert property (acc && STEP_UP |=>
		ADDRESS_POINTER[5:0] == $past(ADDRESS_POINTER[5:0]) + 6'h01) else $error("no step up");
	AST_DN: assert property (acc && !STEP_UP |=>
		ADDRESS_POINTER[5:0] == $past(ADDRESS_POINTER[5:0]) - 6'h01) else $error("no step down");
	AST_GA: assert property (INSTR_WR && HOST_DATA[7:6] == 2'h1 |=> GLYPH_SELECTED &&
		ADDRESS_POINTER == {1'b0, $past(HOST_DATA[5:0])}) else $error("glyph address");
	AST_TA: assert property (INSTR_WR && HOST_DATA[7] |=> !GLYPH_SELECTED &&
		ADDRESS_POINTER == $past(HOST_DATA[6:0])) else $error("text address");
	AST_RV: assert property (acc && DATA_RD |=> RD_VALID) else $error("no read valid");
	AST_ROM: assert property (!cg |=> !USE_CUSTOM && PIXELS == 5'h00) else $error("rom code");
	AST_CG: assert property (cg |=> USE_CUSTOM) else $error("custom code");
	AST_CUR: assert property (cg && !FONT_TALL && ROW_INDEX == 4'h7 |=>
		(PIXELS & $past(CURSOR_ROW)) == $past(CURSOR_ROW)) else $error("cursor lost");
endmodule
bind glyph_ram_lookup glyph_ram_lookup_sva chk (.*);

/* verification/glyph_host_model.sv */
// host processor model issuing strobes
`timescale 1ns/1ns
module glyph_host_model (
	input wire CLOCK,
	output reg INSTR_WR = 0, DATA_WR = 0, DATA_RD = 0,
	output reg [7:0] HOST_DATA = 0
);
	// kind is {instruction, write, read}
	task acc(input [2:0] kind, input [7:0] d);
		begin
			@(posedge CLOCK);
			#1 {INSTR_WR, DATA_WR, DATA_RD} = kind;
			HOST_DATA = d;
			@(posedge CLOCK);
			#1 {INSTR_WR, DATA_WR, DATA_RD} = 3'h0;
			HOST_DATA = ~d; // released bus must not look stable
		end
	endtask
endmodule

/* verification/glyph_ram_lookup_tb.sv */
// self-checking bench for the glyph lookup block
`timescale 1ns/1ns
`define CHK(n, e, s) begin compares++; if ((s) !== (e)) begin error_cnt++; \
	$display("mismatch %s exp %h got %h", n, e, s); end end
module glyph_ram_lookup_tb;
	reg clk = 0, rst = 1, step = 1, font = 0;
	reg [7:0] code = 0;
	reg [3:0] row = 0;
	reg [4:0] cur = 0;
	wire iw, dw, dr, rv, sel, cust, tacc, twr, trd;
	wire [7:0] hd, dh, twd;
	wire [6:0] ptr, tad;
	wire [4:0] pix;
	int error_cnt = 0, compares = 0, i;
	initial forever #5 clk = ~clk;
	glyph_host_model host (.CLOCK(clk), .INSTR_WR(iw), .DATA_WR(dw), .DATA_RD(dr), .HOST_DATA(hd));
	glyph_ram_lookup dut (.CLOCK(clk), .SYS_RST(rst), .INSTR_WR(iw), .DATA_WR(dw), .DATA_RD(dr),
		.HOST_DATA(hd), .STEP_UP(step), .FONT_TALL(font), .DATA_HOLDING_REG(dh), .RD_VALID(rv),
		.ADDRESS_POINTER(ptr), .GLYPH_SELECTED(sel), .TEXT_ACCESS(tacc), .TEXT_ADDR(tad),
		.TEXT_WR(twr), .TEXT_RD(trd), .TEXT_WDATA(twd), .CHAR_CODE(code), .ROW_INDEX(row),
		.CURSOR_ROW(cur),
		.PIXELS(pix), .USE_CUSTOM(cust));
	task t_write;
		begin
			host.acc(3'h4, 8'h48);
			`CHK("sel", 1'b1, sel)
			for (i = 0; i < 8; i++) begin
				host.acc(3'h2, 8'hF0 | i[7:0]);
				`CHK("ptr", 7'h09 + i[6:0], ptr)
			end
			host.acc(3'h4, 8'h85);
			`CHK("text ptr", 7'h05, ptr)
			`CHK("sel", 1'b0, sel)
			$display("write test done");
		end
	endtask
	task t_read;
		begin
			step = 0;
			host.acc(3'h4, 8'h4F);
			host.acc(3'h1, 8'h00);
			// read valid stands for one cycle only, so look right after the read edge
			`CHK("rv", 1'b1, rv)
			`CHK("rdata", 8'hF7, dh)
			`CHK("ptr", 7'h0E, ptr)
			step = 1;
			host.acc(3'h6, 8'h4E);
			`CHK("ptr", 7'h0E, ptr)
			host.acc(3'h1, 8'h00);
			`CHK("rdata", 8'hF6, dh)
			`CHK("ptr", 7'h0F, ptr)
			$display("read test done");
		end
	endtask
	task t_text;
		begin
			host.acc(3'h4, 8'h88);
			`CHK("sel", 1'b0, sel)
			host.acc(3'h2, 8'h3C);
			`CHK("text access", 1'b1, tacc)
			`CHK("text wr", 1'b1, twr)
			`CHK("text wdata", 8'h3C, twd)
			`CHK("text addr", 7'h08, tad)
			`CHK("held data", 8'h3C, dh)
			`CHK("ptr", 7'h09, ptr)
			host.acc(3'h1, 8'h00);
			`CHK("text rd", 1'b1, trd)
			`CHK("text wr", 1'b0, twr)
			`CHK("text addr", 7'h09, tad)
			`CHK("rv", 1'b0, rv)
			`CHK("ptr", 7'h0A, ptr)
			host.acc(3'h4, 8'h48);
			host.acc(3'h1, 8'h00);
			`CHK("rdata", 8'hF0, dh)
			$display("text test done");
		end
	endtask
	task t_disp;
		begin
			cur = 5'h08;
			for (i = 0; i < 16; i++) begin
				code = i[3] ? 8'h09 : 8'h01;
				row = {1'b0, i[2:0]};
				@(posedge clk);
				#1 `CHK("pix", i[2:0] == 3'h7 ? 5'h1F : {2'h2, i[2:0]}, pix)
				`CHK("cust", 1'b1, cust)
			end
			font = 1;
			code = 8'h00;
			row = 4'hF;
			@(posedge clk);
			#1 `CHK("tall pix", 5'h17, pix)
			code = 8'h01;
			row = 4'h8;
			@(posedge clk);
			#1 `CHK("tall pix", 5'h10, pix)
			font = 0;
			code = 8'h11;
			@(posedge clk);
			#1 `CHK("rom pix", 5'h00, pix)
			$display("display test done");
		end
	endtask
	task give_verdict;
		begin
			$display("compares %0d mismatches %0d", compares, error_cnt);
			if (error_cnt == 0 && compares > 0)
				$display("Result: passed");
			else
				$display("Result: failed");
			$finish;
		end
	endtask
	initial begin
		repeat (5) @(posedge clk);
		#1 rst = 0;
		t_write;
		t_read;
		t_text;
		t_disp;
		give_verdict;
	end
endmodule
